// ### include/dao_chan_if.sv
// one converter channel's result as seen by the output routing
// assumes dao_pkg is compiled first
`timescale 1ns/1ns
`default_nettype none
interface dao_chan_if #(parameter int DATA_W = 10) ();
   logic [DATA_W-1:0] word;
   logic flag;
   logic drive;
   logic valid;
   logic locked;
   logic upd;
   dao_pkg::dao_pwr_t pwr;
   modport src (output word, flag, drive, valid, locked, upd, pwr);
   modport dst (input word, flag, drive, valid, locked, upd, pwr);
endinterface
`default_nettype wire

// ### include/dao_defs.svh
// offsets, field positions, reset values and timing counts of the dual
// converter output block; assumes a 100 MHz core clock
`ifndef DAO_DEFS_SVH
`define DAO_DEFS_SVH
`define DAO_ADDR_W 8
`define DAO_REG_CTRL 8'h00
`define DAO_REG_STATUS 8'h04
`define DAO_REG_WORD_A 8'h08
`define DAO_REG_WORD_B 8'h0C
`define DAO_REG_CNT_A 8'h10
`define DAO_REG_CNT_B 8'h14
`define DAO_CTRL_MODE_LSB 0
`define DAO_CTRL_MODE_RST 2'h0
`define DAO_MODE_OB_NODCS 2'h0
`define DAO_MODE_OB_DCS 2'h1
`define DAO_MODE_TC_DCS 2'h2
`define DAO_MODE_TC_NODCS 2'h3
`define DAO_ST_PWR_A_LSB 0
`define DAO_ST_PWR_B_LSB 4
`define DAO_ST_VALID_A 8
`define DAO_ST_VALID_B 9
`define DAO_ST_LOCK_A 10
`define DAO_ST_LOCK_B 11
`define DAO_ST_DCS 12
`define DAO_ST_TWOS 13
`define DAO_WORD_FLAG_BIT 16
`define DAO_CLK_PERIOD_NS 10
`define DAO_SLEEP_WAKE_US 1000
`define DAO_SLEEP_WAKE_CYC ((`DAO_SLEEP_WAKE_US * 1000 + `DAO_CLK_PERIOD_NS - 1) / `DAO_CLK_PERIOD_NS)
`define DAO_DCS_STOP_NS 2000
`define DAO_DCS_STOP_CYC ((`DAO_DCS_STOP_NS + `DAO_CLK_PERIOD_NS - 1) / `DAO_CLK_PERIOD_NS)
`define DAO_NAP_WAKE_EDGES 100
`define DAO_RELOCK_EDGES 100
`define DAO_LATENCY_DEF 5
`endif

// ### include/dao_pkg.sv
// types and mode decode shared by the output block modules
// assumes dao_defs.svh is on the include path
`default_nettype none
`include "dao_defs.svh"
package dao_pkg;
   typedef enum logic [3:0] {
      DAO_PWR_RUN = 4'h1,
      DAO_PWR_NAP = 4'h2,
      DAO_PWR_SLEEP = 4'h4,
      DAO_PWR_WAKE = 4'h8
   } dao_pwr_t;

   function automatic logic dao_twos(input logic [1:0] mode);
      return mode == `DAO_MODE_TC_DCS || mode == `DAO_MODE_TC_NODCS;
   endfunction

   function automatic logic dao_dcs(input logic [1:0] mode);
      return mode == `DAO_MODE_OB_DCS || mode == `DAO_MODE_TC_DCS;
   endfunction
endpackage
`default_nettype wire

// ### rtl/dao_chan.sv
// one converter channel: code format, overrange, power state, clock lock
// assumes sample clock and pin controls synchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
`include "dao_defs.svh"
module dao_chan #(
   parameter int DATA_W = 10,
   parameter int RAW_W = 12,
   parameter int LATENCY = `DAO_LATENCY_DEF,
   parameter int SLEEP_WAKE_CYC = `DAO_SLEEP_WAKE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic signed [RAW_W-1:0] raw_code,
   input wire logic sample_clk,
   input wire logic power_down_req,
   input wire logic output_disable_n,
   input wire logic twos_fmt,
   input wire logic dcs_on,
   dao_chan_if.src chan
);
   localparam int WAIT_W = 17;
   localparam logic signed [RAW_W-1:0] RMAX = RAW_W'(2 ** (DATA_W - 1) - 1);
   localparam logic signed [RAW_W-1:0] RMIN = RAW_W'(-(2 ** (DATA_W - 1)));

   typedef struct packed {
      logic clk_q;
      logic [LATENCY-1:0][DATA_W:0] pipe;
      dao_pkg::dao_pwr_t pwr;
      logic slow_wake;
      logic [WAIT_W-1:0] wait_cnt;
      logic [7:0] stop_cnt;
      logic [7:0] lock_cnt;
      logic locked;
      logic [3:0] fill;
      logic drive;
      logic upd;
   } dao_chan_st_t;

   dao_chan_st_t s;
   dao_chan_st_t next_s;

   // clamp first, then the msb flip is the only difference between formats
   function automatic logic [DATA_W:0] to_code(input logic signed [RAW_W-1:0] v, input logic tc);
      logic signed [RAW_W-1:0] sat;
      logic [DATA_W-1:0] w;
      sat = (v > RMAX) ? RMAX : ((v < RMIN) ? RMIN : v);
      w = sat[DATA_W-1:0];
      if (!tc) begin
         w[DATA_W-1] = ~w[DATA_W-1];
      end
      return {(v > RMAX) || (v < RMIN), w};
   endfunction

   always_comb begin
      logic rise;
      rise = sample_clk & ~s.clk_q;
      next_s = s;
      next_s.clk_q = sample_clk;
      next_s.upd = 1'b0;
      next_s.drive = !power_down_req && !output_disable_n;
      if (power_down_req) begin
         next_s.pwr = output_disable_n ? dao_pkg::DAO_PWR_SLEEP : dao_pkg::DAO_PWR_NAP;
         next_s.slow_wake = output_disable_n;
         next_s.wait_cnt = output_disable_n ? WAIT_W'(SLEEP_WAKE_CYC) : WAIT_W'(`DAO_NAP_WAKE_EDGES);
         next_s.fill = 4'h0;
      end else begin
         unique case (s.pwr)
            dao_pkg::DAO_PWR_RUN: begin
            end
            dao_pkg::DAO_PWR_NAP, dao_pkg::DAO_PWR_SLEEP: begin
               next_s.pwr = dao_pkg::DAO_PWR_WAKE;
            end
            dao_pkg::DAO_PWR_WAKE: begin
               // sleep recovery is timed in core cycles, nap recovery in samples
               if (s.wait_cnt == '0) begin
                  next_s.pwr = dao_pkg::DAO_PWR_RUN;
               end else if (s.slow_wake || rise) begin
                  next_s.wait_cnt = s.wait_cnt - WAIT_W'(1);
               end
            end
         endcase
      end
      if (!dcs_on) begin
         next_s.locked = 1'b1;
         next_s.stop_cnt = 8'h00;
         next_s.lock_cnt = 8'h00;
      end else if (rise) begin
         next_s.stop_cnt = 8'h00;
         if (!s.locked && s.lock_cnt == 8'(`DAO_RELOCK_EDGES - 1)) begin
            next_s.locked = 1'b1;
         end else if (!s.locked) begin
            next_s.lock_cnt = s.lock_cnt + 8'h01;
         end
      end else if (s.stop_cnt == 8'(`DAO_DCS_STOP_CYC - 1)) begin
         next_s.locked = 1'b0;
         next_s.lock_cnt = 8'h00;
      end else begin
         next_s.stop_cnt = s.stop_cnt + 8'h01;
      end
      // only the rising sample edge converts, with or without the stabilizer
      if (rise && !power_down_req && (s.pwr == dao_pkg::DAO_PWR_RUN || s.pwr == dao_pkg::DAO_PWR_WAKE)) begin
         next_s.pipe[0] = to_code(raw_code, twos_fmt);
         for (int i = 1; i < LATENCY; i++) begin
            next_s.pipe[i] = s.pipe[i-1];
         end
         next_s.upd = 1'b1;
         if (s.fill != 4'(LATENCY)) begin
            next_s.fill = s.fill + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.pwr <= dao_pkg::DAO_PWR_RUN;
         s.locked <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign chan.word = s.pipe[LATENCY-1][DATA_W-1:0];
   assign chan.flag = s.pipe[LATENCY-1][DATA_W];
   assign chan.drive = s.drive;
   assign chan.valid = s.pwr == dao_pkg::DAO_PWR_RUN && s.locked && s.fill == 4'(LATENCY);
   assign chan.locked = s.locked;
   assign chan.upd = s.upd;
   assign chan.pwr = s.pwr;

   a_ob_zero_code: assert property (@(posedge core_clk) disable iff (rst)
      next_s.upd && !twos_fmt && raw_code == '0 |=> s.pipe[0] == {1'b0, 1'b1, {(DATA_W-1){1'b0}}})
      else $error("offset binary zero code wrong");
   a_tc_top_code: assert property (@(posedge core_clk) disable iff (rst)
      next_s.upd && twos_fmt && raw_code == RMAX |=> s.pipe[0] == {1'b0, 1'b0, {(DATA_W-1){1'b1}}})
      else $error("twos complement top code wrong");
   a_over_flag: assert property (@(posedge core_clk) disable iff (rst)
      next_s.upd && raw_code < RMIN |=> s.pipe[0][DATA_W] && s.pipe[0][DATA_W-2:0] == '0)
      else $error("underrange not flagged or not saturated");
endmodule
`default_nettype wire

// ### rtl/dao_top.sv
// dual converter digital output side: two channels, bus swap, APB control
// assumes all pins synchronous to core_clk; tristate resolved outside
//
// Functional notes
// - offset binary: top all ones, zero midscale
// - twos complement is offset binary, msb inverted
// - overrange raises flag and saturates the word
// - four mode codes pick format and stabilizer
// - one mode setting serves both channels
// - disable level floats channel word and flag
// - each channel has its own disable input
// - power down low means normal conversion
// - power down with disable gives sleep, slow wake
// - power down while enabled gives nap, 100-sample wake
// - sleep and nap float all channel outputs
// - channels power and float independently
// - swap high: channel A on bus A
// - swap low: channels cross to opposite buses
// - stabilizer samples rising edge, relocks in 100 sample edges
`timescale 1ns/1ns
`default_nettype none
`include "dao_defs.svh"
module dao_top #(
   parameter int DATA_W = 10,
   parameter int RAW_W = 12,
   parameter int LATENCY = `DAO_LATENCY_DEF,
   parameter int SLEEP_WAKE_CYC = `DAO_SLEEP_WAKE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`DAO_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [RAW_W-1:0] raw_code_chan_a,
   input wire logic signed [RAW_W-1:0] raw_code_chan_b,
   input wire logic sample_clock_chan_a,
   input wire logic sample_clock_chan_b,
   input wire logic power_down_req_chan_a,
   input wire logic power_down_req_chan_b,
   input wire logic output_disable_n_chan_a,
   input wire logic output_disable_n_chan_b,
   input wire logic bus_swap_sel,
   output logic [DATA_W-1:0] output_bus_a_word,
   output logic range_exceeded_flag_bus_a,
   output logic output_bus_a_oe_n,
   output logic [DATA_W-1:0] output_bus_b_word,
   output logic range_exceeded_flag_bus_b,
   output logic output_bus_b_oe_n
);
   // the wake counter is 17 bits and the fill counter 4 bits wide
   if (RAW_W <= DATA_W || DATA_W < 2 || DATA_W > `DAO_WORD_FLAG_BIT) begin : g_bad_width
      $error("dao_top: unsupported word widths");
   end
   if (LATENCY < 2 || LATENCY > 15) begin : g_bad_latency
      $error("dao_top: latency must be 2 to 15 samples");
   end
   if (SLEEP_WAKE_CYC < 1 || SLEEP_WAKE_CYC > 131071) begin : g_bad_wake
      $error("dao_top: sleep wake count out of range");
   end

   typedef struct packed {
      logic [1:0] mode;
      logic [DATA_W-1:0] bus_a;
      logic [DATA_W-1:0] bus_b;
      logic flag_a;
      logic flag_b;
      logic oe_a_n;
      logic oe_b_n;
      logic [31:0] prdata;
      logic slverr;
      logic [31:0] cnt_a;
      logic [31:0] cnt_b;
   } dao_top_st_t;

   dao_top_st_t s;
   dao_top_st_t next_s;
   logic twos_fmt;
   logic dcs_on;

   dao_chan_if #(.DATA_W(DATA_W)) ca ();
   dao_chan_if #(.DATA_W(DATA_W)) cb ();

   function automatic logic reg_hit(input logic [`DAO_ADDR_W-1:0] a);
      return a == `DAO_REG_CTRL || a == `DAO_REG_STATUS || a == `DAO_REG_WORD_A ||
             a == `DAO_REG_WORD_B || a == `DAO_REG_CNT_A || a == `DAO_REG_CNT_B;
   endfunction

   function automatic logic [31:0] word_reg(input logic [DATA_W-1:0] w, input logic f);
      logic [31:0] r;
      r = '0;
      r[DATA_W-1:0] = w;
      r[`DAO_WORD_FLAG_BIT] = f;
      return r;
   endfunction

   function automatic logic [31:0] status_reg(input logic [1:0] mode);
      logic [31:0] r;
      r = '0;
      r[`DAO_ST_PWR_A_LSB +: 4] = ca.pwr;
      r[`DAO_ST_PWR_B_LSB +: 4] = cb.pwr;
      r[`DAO_ST_VALID_A] = ca.valid;
      r[`DAO_ST_VALID_B] = cb.valid;
      r[`DAO_ST_LOCK_A] = ca.locked;
      r[`DAO_ST_LOCK_B] = cb.locked;
      r[`DAO_ST_DCS] = dao_pkg::dao_dcs(mode);
      r[`DAO_ST_TWOS] = dao_pkg::dao_twos(mode);
      return r;
   endfunction

   // a single mode field feeds both channels, so formats cannot diverge
   assign twos_fmt = dao_pkg::dao_twos(s.mode);
   assign dcs_on = dao_pkg::dao_dcs(s.mode);

   // each channel sees only its own power and disable pins
   dao_chan #(
      .DATA_W(DATA_W),
      .RAW_W(RAW_W),
      .LATENCY(LATENCY),
      .SLEEP_WAKE_CYC(SLEEP_WAKE_CYC)
   ) u_chan_a (
      .core_clk(core_clk),
      .rst(rst),
      .raw_code(raw_code_chan_a),
      .sample_clk(sample_clock_chan_a),
      .power_down_req(power_down_req_chan_a),
      .output_disable_n(output_disable_n_chan_a),
      .twos_fmt(twos_fmt),
      .dcs_on(dcs_on),
      .chan(ca.src)
   );

   dao_chan #(
      .DATA_W(DATA_W),
      .RAW_W(RAW_W),
      .LATENCY(LATENCY),
      .SLEEP_WAKE_CYC(SLEEP_WAKE_CYC)
   ) u_chan_b (
      .core_clk(core_clk),
      .rst(rst),
      .raw_code(raw_code_chan_b),
      .sample_clk(sample_clock_chan_b),
      .power_down_req(power_down_req_chan_b),
      .output_disable_n(output_disable_n_chan_b),
      .twos_fmt(twos_fmt),
      .dcs_on(dcs_on),
      .chan(cb.src)
   );

   always_comb begin
      logic setup;
      logic wr;
      logic clr_a;
      logic clr_b;
      setup = psel && !penable;
      wr = psel && penable && pwrite;
      clr_a = wr && paddr == `DAO_REG_CNT_A;
      clr_b = wr && paddr == `DAO_REG_CNT_B;
      next_s = s;
      // the enable follows whichever channel is routed onto the bus
      if (bus_swap_sel) begin
         next_s.bus_a = ca.word;
         next_s.flag_a = ca.flag;
         next_s.oe_a_n = !ca.drive;
         next_s.bus_b = cb.word;
         next_s.flag_b = cb.flag;
         next_s.oe_b_n = !cb.drive;
      end else begin
         next_s.bus_a = cb.word;
         next_s.flag_a = cb.flag;
         next_s.oe_a_n = !cb.drive;
         next_s.bus_b = ca.word;
         next_s.flag_b = ca.flag;
         next_s.oe_b_n = !ca.drive;
      end
      // read data is captured in the setup phase so prdata is a flop output
      if (setup) begin
         next_s.slverr = !reg_hit(paddr);
         unique case (paddr)
            `DAO_REG_CTRL: next_s.prdata = {30'h0, s.mode};
            `DAO_REG_STATUS: next_s.prdata = status_reg(s.mode);
            `DAO_REG_WORD_A: next_s.prdata = word_reg(ca.word, ca.flag);
            `DAO_REG_WORD_B: next_s.prdata = word_reg(cb.word, cb.flag);
            `DAO_REG_CNT_A: next_s.prdata = s.cnt_a;
            `DAO_REG_CNT_B: next_s.prdata = s.cnt_b;
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end
      if (wr && paddr == `DAO_REG_CTRL) begin
         next_s.mode = pwdata[`DAO_CTRL_MODE_LSB +: 2];
      end
      // a sample landing on the clearing write is still counted
      next_s.cnt_a = (clr_a ? 32'h0000_0000 : s.cnt_a) + {31'h0, ca.upd};
      next_s.cnt_b = (clr_b ? 32'h0000_0000 : s.cnt_b) + {31'h0, cb.upd};
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.mode <= `DAO_CTRL_MODE_RST;
         s.oe_a_n <= 1'b1;
         s.oe_b_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && s.slverr;
   assign prdata = s.prdata;
   assign output_bus_a_word = s.bus_a;
   assign range_exceeded_flag_bus_a = s.flag_a;
   assign output_bus_a_oe_n = s.oe_a_n;
   assign output_bus_b_word = s.bus_b;
   assign range_exceeded_flag_bus_b = s.flag_b;
   assign output_bus_b_oe_n = s.oe_b_n;

   a_swap_high_route: assert property (@(posedge core_clk) disable iff (rst)
      bus_swap_sel |=> output_bus_a_word == $past(ca.word) && range_exceeded_flag_bus_a == $past(ca.flag)
         && output_bus_b_word == $past(cb.word))
      else $error("swap high routing wrong");

   a_swap_low_route: assert property (@(posedge core_clk) disable iff (rst)
      !bus_swap_sel |=> output_bus_b_word == $past(ca.word) && range_exceeded_flag_bus_b == $past(ca.flag)
         && output_bus_a_word == $past(cb.word))
      else $error("swap low routing wrong");

   a_disable_float_a: assert property (@(posedge core_clk) disable iff (rst)
      (output_disable_n_chan_a && bus_swap_sel) [*4] |-> output_bus_a_oe_n)
      else $error("disabled channel A still drives");

   a_disable_own_b: assert property (@(posedge core_clk) disable iff (rst)
      (output_disable_n_chan_a && !output_disable_n_chan_b && !power_down_req_chan_b && bus_swap_sel) [*4]
         |-> !output_bus_b_oe_n && output_bus_a_oe_n)
      else $error("channel B disable not independent");

   a_powerdown_float: assert property (@(posedge core_clk) disable iff (rst)
      (power_down_req_chan_b && !bus_swap_sel) [*4] |-> output_bus_a_oe_n)
      else $error("powered down channel B still drives");

   a_sleep_enter: assert property (@(posedge core_clk) disable iff (rst)
      power_down_req_chan_a && output_disable_n_chan_a |=> ca.pwr == dao_pkg::DAO_PWR_SLEEP && !ca.valid)
      else $error("sleep not entered");

   a_nap_enter: assert property (@(posedge core_clk) disable iff (rst)
      power_down_req_chan_b && !output_disable_n_chan_b |=> cb.pwr == dao_pkg::DAO_PWR_NAP && !cb.drive)
      else $error("nap not entered");

   a_nap_no_early: assert property (@(posedge core_clk) disable iff (rst)
      cb.pwr == dao_pkg::DAO_PWR_NAP ##1 !power_down_req_chan_b && cb.pwr == dao_pkg::DAO_PWR_NAP
         |=> (cb.pwr == dao_pkg::DAO_PWR_WAKE && !cb.valid) [*2])
      else $error("nap exit valid too early");

   a_run_normal: assert property (@(posedge core_clk) disable iff (rst)
      !power_down_req_chan_a && !output_disable_n_chan_a && ca.pwr == dao_pkg::DAO_PWR_RUN
         |=> ca.drive && ca.pwr == dao_pkg::DAO_PWR_RUN)
      else $error("normal operation left unexpectedly");

   a_indep_power: assert property (@(posedge core_clk) disable iff (rst)
      power_down_req_chan_a && !power_down_req_chan_b |=> cb.pwr != dao_pkg::DAO_PWR_NAP
         && cb.pwr != dao_pkg::DAO_PWR_SLEEP && ca.pwr != dao_pkg::DAO_PWR_RUN)
      else $error("channel power states coupled");

   a_mode_decode: assert property (@(posedge core_clk) disable iff (rst)
      (s.mode == 2'h0 |-> !twos_fmt && !dcs_on) and (s.mode == 2'h1 |-> !twos_fmt && dcs_on)
         and (s.mode == 2'h2 |-> twos_fmt && dcs_on) and (s.mode == 2'h3 |-> twos_fmt && !dcs_on))
      else $error("mode decode wrong");

   a_relock_hold: assert property (@(posedge core_clk) disable iff (rst)
      dcs_on && !ca.locked |-> !ca.valid)
      else $error("valid while stabilizer unlocked");

   a_mode_write: assert property (@(posedge core_clk) disable iff (rst)
      psel && penable && pwrite && paddr == `DAO_REG_CTRL |=> s.mode == $past(pwdata[1:0]))
      else $error("mode write lost");

   a_count_step: assert property (@(posedge core_clk) disable iff (rst)
      ca.upd && !(psel && penable && pwrite && paddr == `DAO_REG_CNT_A) |=> s.cnt_a == $past(s.cnt_a) + 32'h1)
      else $error("sample count missed an update");

   a_unmapped_err: assert property (@(posedge core_clk) disable iff (rst)
      psel && !penable && !reg_hit(paddr) ##1 psel && penable |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ### sim/dao_capture.sv
// capture register standing in for the downstream latch logic
// assumes bus pins are synchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
module dao_capture (
   input wire logic core_clk,
   input wire logic [9:0] word,
   input wire logic flag,
   input wire logic oe_n,
   output logic [10:0] cap
);
   // a floating bus is never latched, so a disabled bus shows as a stale hold
   always_ff @(posedge core_clk) begin
      if (!oe_n) begin
         cap <= {flag, word};
      end
   end
endmodule
`default_nettype wire

// ### sim/test_dao_top.sv
// self-checking bench for the dual converter output block
// assumes dao_pkg, dao_chan_if, the design files and dao_capture compiled first
`timescale 1ns/1ns
`default_nettype none
`include "dao_defs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_dao_top;
   logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [`DAO_ADDR_W-1:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, sclk = 0, swap = 1;
   logic signed [11:0] raw_a = 0, raw_b = 0;
   logic pd_a = 0, pd_b = 0, dis_a = 0, dis_b = 0;
   logic [9:0] wa, wb;
   logic fa, fb, oa, ob;
   logic [10:0] cap_a, cap_b;
   int failures = 0, tests_run = 0, cyc = 0;
   always #5 core_clk = ~core_clk;
   // one sample clock feeds both channels so they never drift apart
   dao_top #(.LATENCY(2), .SLEEP_WAKE_CYC(20)) dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .raw_code_chan_a(raw_a), .raw_code_chan_b(raw_b),
      .sample_clock_chan_a(sclk), .sample_clock_chan_b(sclk),
      .power_down_req_chan_a(pd_a), .power_down_req_chan_b(pd_b), .output_disable_n_chan_a(dis_a),
      .output_disable_n_chan_b(dis_b), .bus_swap_sel(swap), .output_bus_a_word(wa),
      .range_exceeded_flag_bus_a(fa), .output_bus_a_oe_n(oa), .output_bus_b_word(wb),
      .range_exceeded_flag_bus_b(fb), .output_bus_b_oe_n(ob));
   dao_capture cpa (.core_clk, .word(wa), .flag(fa), .oe_n(oa), .cap(cap_a));
   dao_capture cpb (.core_clk, .word(wb), .flag(fb), .oe_n(ob), .cap(cap_b));

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      // no cycle count is assumed; a silent slave ends in the bench timeout
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         sclk <= 1;
         @(posedge core_clk);
         sclk <= 0;
         @(posedge core_clk);
      end
      repeat (3) @(posedge core_clk);
   endtask

   function automatic logic [10:0] expv(input logic signed [11:0] r, input logic tc);
      logic [10:0] v;
      if (r > 511) v = 11'h7FF;
      else if (r < -512) v = 11'h400;
      else v = {1'b0, r[9:0] ^ 10'h200};
      v[9] = v[9] ^ tc;
      return v;
   endfunction

   task automatic t_format();
      logic signed [11:0] vals [5] = '{12'sh1FF, 12'sh000, 12'shE00, 12'sh258, 12'shDA8};
      for (int m = 0; m < 4; m++) begin
         apb(1, `DAO_REG_CTRL, 32'(m));
         apb(0, `DAO_REG_STATUS, 0);
         `CHK(rd[13:12], {m[1], m == 1 || m == 2})
         pulse(110);
         foreach (vals[i]) begin
            raw_a <= vals[i];
            raw_b <= -vals[i];
            pulse(6);
            `CHK(cap_a, expv(vals[i], m[1]))
            `CHK(cap_b, expv(-vals[i], m[1]))
         end
         // a stopped sample clock must drop the stabilizer lock and valid
         if (m == 1) begin
            repeat (210) @(posedge core_clk);
            apb(0, `DAO_REG_STATUS, 0);
            `CHK(rd[11:8], 4'h0)
            pulse(110);
            apb(0, `DAO_REG_STATUS, 0);
            `CHK(rd[11:8], 4'hF)
         end
      end
      $display("format test done");
   endtask

   task automatic t_swap();
      apb(1, `DAO_REG_CTRL, 0);
      raw_a <= 12'sh005;
      raw_b <= 12'shFF9;
      swap <= 0;
      pulse(6);
      `CHK(cap_b, expv(12'sh005, 0))
      `CHK(cap_a, expv(12'shFF9, 0))
      swap <= 1;
      pulse(6);
      `CHK(cap_a, expv(12'sh005, 0))
      `CHK(cap_b, expv(12'shFF9, 0))
      apb(0, `DAO_REG_WORD_B, 0);
      `CHK({rd[16], rd[9:0]}, expv(12'shFF9, 0))
      // multiplexed use: swap follows the shared sample clock
      sclk <= 1;
      swap <= 1;
      repeat (4) begin
         @(posedge core_clk);
         sclk <= 0;
         swap <= 0;
         @(negedge core_clk);
         `CHK({fa, wa}, expv(12'sh005, 0))
         @(posedge core_clk);
         sclk <= 1;
         swap <= 1;
         @(negedge core_clk);
         `CHK({fa, wa}, expv(12'shFF9, 0))
         `CHK(cap_a, expv(12'sh005, 0))
      end
      @(posedge core_clk);
      sclk <= 0;
      $display("swap test done");
   endtask

   task automatic t_power();
      dis_a <= 1;
      pulse(2);
      `CHK({oa, ob}, 2'b10)
      pd_a <= 1;
      pulse(2);
      apb(0, `DAO_REG_STATUS, 0);
      `CHK(rd[7:0], 8'h14)
      pd_a <= 0;
      dis_a <= 0;
      pulse(30);
      pd_b <= 1;
      pulse(2);
      `CHK({oa, ob}, 2'b01)
      apb(0, `DAO_REG_STATUS, 0);
      `CHK(rd[7:0], 8'h21)
      pd_b <= 0;
      pulse(110);
      `CHK({oa, ob}, 2'b00)
      apb(0, `DAO_REG_STATUS, 0);
      `CHK(rd[9:0], 10'h311)
      $display("power test done");
   endtask

   task automatic t_bus();
      apb(1, 8'hFC, 32'h1);
      `CHK(err, 1'b1)
      apb(0, 8'h02, 0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1, `DAO_REG_STATUS, 32'hFFFFFFFF);
      `CHK(err, 1'b0)
      `CHK(pready, 1'b1)
      apb(1, `DAO_REG_CNT_B, 0);
      pulse(5);
      apb(0, `DAO_REG_CNT_B, 0);
      `CHK(rd, 32'h0000_0005)
      $display("bus test done");
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         close_out();
      end
   end

   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      t_format();
      t_swap();
      t_power();
      t_bus();
      close_out();
   end
endmodule
`default_nettype wire
